//--- verilog/irhr_pkg.sv
// Shared constants and types for the infrared host register bank.
// Assumes a 50 MHz single clock and a classic Wishbone register bus.
`default_nettype none

package irhr_pkg;

    // ========================================================
    // Bus geometry and register indices (byte address = 4*index)
    localparam int ADR_W = 5;
    localparam logic [2:0] IDX_DATA = 3'h0; // Data ports or divisor low
    localparam logic [2:0] IDX_IEN = 3'h1; // Enables or divisor high
    localparam logic [2:0] IDX_SRC = 3'h2; // Interrupt source
    localparam logic [2:0] IDX_LCTL = 3'h3; // Line control
    localparam logic [2:0] IDX_CFG = 3'h4; // Mode and thresholds
    localparam logic [2:0] IDX_STAT = 3'h5; // Status FIFO port

    // ========================================================
    // Field positions
    localparam int LCTL_DIV_BIT = 7;
    localparam int BIT_RX_THR = 0;
    localparam int BIT_TX_THR = 1;
    localparam int BIT_LAST_RD = 2;
    localparam int BIT_TIMEOUT = 2;
    localparam int BIT_OVERRUN = 3;
    localparam int BIT_STAT_THR = 4;
    localparam int BIT_UNDERRUN = 5;
    localparam int BIT_TC = 6;
    localparam int BIT_EOF = 7;

    // ========================================================
    // Modes and the enable bits each mode uses
    localparam logic [1:0] MODE_PIO = 2'h0;
    localparam logic [1:0] MODE_DMA = 2'h1;
    localparam logic [1:0] MODE_REMOTE = 2'h2;
    localparam logic [7:0] MASK_PIO = 8'hAF;
    localparam logic [7:0] MASK_DMA = 8'h74;
    localparam logic [7:0] MASK_REMOTE = 8'h2B;

    // ========================================================
    // Reset values
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [7:0] LCTL_RST = 8'h00;
    localparam logic [7:0] DIV_LOW_RST = 8'h01;
    localparam logic [7:0] DIV_HIGH_RST = 8'h00;
    localparam logic [31:0] CFG_RST = 32'h0101_0100;

    // ========================================================
    // Inter-frame gap timing
    localparam int GAP_TIME_US = 1000;
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int GAP_CYCLES = GAP_TIME_US * (CLK_FREQ_HZ / 1_000_000);

    // ========================================================
    // Carriers
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } irhr_rx_entry_s;

    typedef struct packed {
        logic [7:0] stat_thr;
        logic [7:0] tx_thr;
        logic [7:0] rx_thr;
        logic [5:0] spare;
        logic [1:0] mode;
    } irhr_cfg_s;

endpackage

`default_nettype wire

//--- verilog/irhr_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the input is a slow level; only the second stage is read outside.
`default_nettype none

module irhr_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    // ========================================================
    // Synchroniser chain; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire

//--- verilog/irhr_fifo.sv
// Small synchronous FIFO with a registered head word.
// Assumes one clock; push when full and pop when empty are ignored.
`default_nettype none

module irhr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic [W-1:0] push_data_i,
    input wire logic pop_i,
    output logic [W-1:0] head_o,
    output logic head_ok_o,
    output logic [$clog2(DEPTH):0] level_o,
    output logic full_o
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    wire do_push = push_i & ~full_o;
    wire do_pop = pop_i & head_ok_o;

    assign full_o = (level_o == (AW+1)'(DEPTH));

    // ========================================================
    // Storage; head is re-read every cycle so it tracks the pointer
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wptr_q] <= push_data_i;
        end
        head_o <= mem_q[rptr_q];
    end

    // Pointers and level. Head is flagged stale for one cycle after a
    // pop, trading throughput for a plain registered read path.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            level_o <= '0;
            head_ok_o <= 1'b0;
        end else begin
            if (do_push) wptr_q <= wptr_q + 1'b1;
            if (do_pop) rptr_q <= rptr_q + 1'b1;
            level_o <= level_o + (AW+1)'(do_push) - (AW+1)'(do_pop);
            head_ok_o <= (level_o != '0) & ~do_pop;
        end
    end

endmodule

`default_nettype wire

//--- verilog/irhr_top.sv
// Host register bank of a serial infrared controller: divisor latches,
// receive/transmit data ports, per-mode interrupt enables and sources.
// Assumes a classic Wishbone master and a line coder on the same clock;
// only the terminal-count pin comes from outside the clock domain.
`default_nettype none

// What this block does
// - Divisor access set: index 0 reads and writes the divisor low byte.
// - Divisor access set: index 1 writes the divisor high byte only.
// - Divisor access clear: reading index 0 pops the receive FIFO.
// - Divisor access clear: writing index 0 pushes the transmit FIFO.
// - Interrupt enables reachable at index 1 only with divisor access clear.
// - PIO mode, enable 0: receive level at or above threshold.
// - PIO mode, enable 1: transmit level below threshold.
// - PIO mode, enable 2: host read the last byte of a frame.
// - PIO mode, enables 3, 5, 7: overrun, underrun, end of frame.
// - DMA mode, enable 2: one millisecond gap after a frame.
// - DMA mode, enable 4: status FIFO level at or above threshold.
// - DMA mode, enables 5 and 6: underrun and terminal count.
// - Remote mode, enables 0 and 1: receive and transmit thresholds.
// - Remote mode, enables 3 and 5; other enable bits unused.
// - Interrupt source sits at index 2 and is read only.
// - PIO end-of-frame flag sets on receive, before last-read, clears on read.
// - DMA terminal-count flag clears when the status FIFO is read.
module irhr_top #(
    parameter int RX_DEPTH = 16,
    parameter int TX_DEPTH = 16,
    parameter int STAT_DEPTH = 8,
    parameter int GAP_CYCLES = irhr_pkg::GAP_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [irhr_pkg::ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_last_i,
    input wire logic tx_active_i,
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic dma_tc_i,
    output logic [15:0] baud_div_o,
    output logic irq_o
);

    localparam int RXW = $clog2(RX_DEPTH);
    localparam int TXW = $clog2(TX_DEPTH);
    localparam int STW = $clog2(STAT_DEPTH);
    localparam int GW = $clog2(GAP_CYCLES + 1);

    // ========================================================
    // Elaboration checks
    if (RX_DEPTH < 2 || RX_DEPTH > 255 || (1 << RXW) != RX_DEPTH)
        $error("RX_DEPTH must be a power of two from 2 to 128");
    if (TX_DEPTH < 2 || TX_DEPTH > 255 || (1 << TXW) != TX_DEPTH)
        $error("TX_DEPTH must be a power of two from 2 to 128");
    if (STAT_DEPTH < 1 || STAT_DEPTH > 255)
        $error("STAT_DEPTH must be from 1 to 255");
    if (GAP_CYCLES < 2)
        $error("GAP_CYCLES must be at least 2");

    // ========================================================
    // Helpers
    function automatic logic [7:0] mode_mask(input logic [1:0] m);
        mode_mask = (m == irhr_pkg::MODE_PIO) ? irhr_pkg::MASK_PIO :
                    (m == irhr_pkg::MODE_DMA) ? irhr_pkg::MASK_DMA :
                    (m == irhr_pkg::MODE_REMOTE) ? irhr_pkg::MASK_REMOTE :
                    8'h00;
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] sel);
        lane_merge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) lane_merge[8*i +: 8] = nw[8*i +: 8];
        end
    endfunction

    // ========================================================
    // Registers
    logic [7:0] div_low_q;
    logic [7:0] div_high_q;
    logic [7:0] ien_q;
    logic [7:0] lctl_q;
    irhr_pkg::irhr_cfg_s cfg_q;
    logic [7:0] src_q;
    logic [7:0] src_d;
    logic [STW:0] stat_cnt_q;
    logic [GW-1:0] gap_q;
    logic tc_prev_q;

    // ========================================================
    // Bus decode; a request is taken in the cycle before ack
    wire bus_req = cyc_i & stb_i & ~ack_o;
    wire bus_wr = bus_req & we_i;
    wire bus_rd = bus_req & ~we_i;
    wire [2:0] idx = adr_i[4:2];
    wire div_acc = lctl_q[irhr_pkg::LCTL_DIV_BIT];
    wire lane0 = sel_i[0];
    wire at_data = (idx == irhr_pkg::IDX_DATA);
    wire at_ien = (idx == irhr_pkg::IDX_IEN);
    wire wr_div_low = bus_wr & lane0 & at_data & div_acc;
    wire wr_div_high = bus_wr & lane0 & at_ien & div_acc;
    wire wr_tx = bus_wr & lane0 & at_data & ~div_acc;
    wire wr_ien = bus_wr & lane0 & at_ien & ~div_acc;
    wire wr_lctl = bus_wr & lane0 & (idx == irhr_pkg::IDX_LCTL);
    wire wr_cfg = bus_wr & (idx == irhr_pkg::IDX_CFG);
    wire rd_rx = bus_rd & at_data & ~div_acc;
    wire rd_src = bus_rd & (idx == irhr_pkg::IDX_SRC);
    wire rd_stat = bus_rd & (idx == irhr_pkg::IDX_STAT);

    // ========================================================
    // Mode view; enables outside the mode are ignored
    wire [1:0] mode = cfg_q.mode;
    wire is_pio = (mode == irhr_pkg::MODE_PIO);
    wire is_dma = (mode == irhr_pkg::MODE_DMA);
    wire [7:0] mmask = mode_mask(mode);
    wire [7:0] ien_eff = ien_q & mmask;

    // ========================================================
    // Receive FIFO, filled by the receiver, drained by host reads
    irhr_pkg::irhr_rx_entry_s rx_push_w;
    irhr_pkg::irhr_rx_entry_s rx_head_w;
    logic rx_ok;
    logic rx_full;
    logic [RXW:0] rx_level;

    assign rx_push_w = '{last: rx_last_i, data: rx_data_i};

    irhr_fifo #(
        .W($bits(irhr_pkg::irhr_rx_entry_s)),
        .DEPTH(RX_DEPTH)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(rx_valid_i),
        .push_data_i(rx_push_w),
        .pop_i(rd_rx),
        .head_o(rx_head_w),
        .head_ok_o(rx_ok),
        .level_o(rx_level),
        .full_o(rx_full)
    );

    // ========================================================
    // Transmit FIFO, filled by host writes, drained into the stage
    logic [7:0] tx_head;
    logic tx_ok;
    logic [TXW:0] tx_level;
    wire tx_load = tx_ok & (~tx_valid_o | tx_ready_i);

    irhr_fifo #(
        .W(8),
        .DEPTH(TX_DEPTH)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(wr_tx),
        .push_data_i(dat_i[7:0]),
        .pop_i(tx_load),
        .head_o(tx_head),
        .head_ok_o(tx_ok),
        .level_o(tx_level),
        .full_o()
    );

    // Output stage toward the transmit line coder
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o <= 8'h00;
        end else if (tx_load) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= tx_head;
        end else if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
        end
    end

    // ========================================================
    // Terminal-count pin: synchronised, then rising edge found
    logic tc_sync;

    irhr_sync #(
        .W(1)
    ) u_tc_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(dma_tc_i),
        .sync_o(tc_sync)
    );

    wire tc_rise = tc_sync & ~tc_prev_q;

    // ========================================================
    // Status FIFO: one entry per frame end in DMA mode; a host read
    // pops one. Only the count is kept, the frame records live elsewhere.
    wire frame_end = rx_valid_i & rx_last_i;
    wire stat_full = (stat_cnt_q == (STW+1)'(STAT_DEPTH));
    wire stat_push = is_dma & frame_end & ~stat_full;
    wire stat_pop = rd_stat & (stat_cnt_q != '0);
    wire gap_hit = (gap_q == GW'(GAP_CYCLES - 1));

    // Gap timer counts idle cycles while frames wait to be reported
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_cnt_q <= '0;
            gap_q <= '0;
            tc_prev_q <= 1'b0;
        end else begin
            stat_cnt_q <= stat_cnt_q + (STW+1)'(stat_push)
                          - (STW+1)'(stat_pop);
            if (rx_valid_i || stat_pop || stat_cnt_q == '0) begin
                gap_q <= '0;
            end else if (gap_q != GW'(GAP_CYCLES)) begin
                gap_q <= gap_q + 1'b1;
            end
            tc_prev_q <= tc_sync;
        end
    end

    // ========================================================
    // Interrupt sources per mode
    wire any_rx = ~is_dma;
    // Levels widen to the threshold, so a large threshold never wraps
    wire rx_thr_hit = 8'(rx_level) >= cfg_q.rx_thr;
    wire tx_thr_low = 8'(tx_level) < cfg_q.tx_thr;
    wire stat_thr_hit = 9'(stat_cnt_q) >= 9'(cfg_q.stat_thr);
    wire last_read = is_pio & rd_rx & rx_ok & rx_head_w.last;
    wire underrun = tx_active_i & tx_ready_i & ~tx_valid_o;
    logic [7:0] src_set;
    logic [7:0] src_clr;

    assign src_set[irhr_pkg::BIT_RX_THR] = any_rx & rx_thr_hit;
    assign src_set[irhr_pkg::BIT_TX_THR] = any_rx & tx_thr_low;
    assign src_set[irhr_pkg::BIT_LAST_RD] = last_read |
        (is_dma & gap_hit);
    assign src_set[irhr_pkg::BIT_OVERRUN] =
        any_rx & rx_valid_i & rx_full;
    // The level before a pop must not re-arm the bit that read clears
    assign src_set[irhr_pkg::BIT_STAT_THR] =
        is_dma & stat_thr_hit & ~rd_stat;
    assign src_set[irhr_pkg::BIT_UNDERRUN] = underrun;
    assign src_set[irhr_pkg::BIT_TC] = is_dma & tc_rise;
    assign src_set[irhr_pkg::BIT_EOF] = is_pio & frame_end;

    // Reading the source clears it; a status FIFO read clears the DMA
    // bits tied to it. A set in the same cycle wins over either clear.
    assign src_clr = (rd_src ? 8'hFF : 8'h00) |
        ((rd_stat & is_dma) ? 8'h54 : 8'h00);
    assign src_d = ((src_q & ~src_clr) | src_set) & mmask;

    // ========================================================
    // Read data selection
    wire [7:0] rx_byte = rx_ok ? rx_head_w.data : 8'h00;
    wire [31:0] rd_data =
        at_data ? {24'h0, div_acc ? div_low_q : rx_byte} :
        at_ien ? {24'h0, div_acc ? 8'h00 : ien_q} :
        (idx == irhr_pkg::IDX_SRC) ? {24'h0, src_q} :
        (idx == irhr_pkg::IDX_LCTL) ? {24'h0, lctl_q} :
        (idx == irhr_pkg::IDX_CFG) ? cfg_q :
        (idx == irhr_pkg::IDX_STAT) ? {{(31-STW){1'b0}}, stat_cnt_q} :
        32'h0;

    // ========================================================
    // Bus answer: one wait state, then ack for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_rd ? rd_data : 32'h0;
        end
    end

    // ========================================================
    // Software-written registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_low_q <= irhr_pkg::DIV_LOW_RST;
            div_high_q <= irhr_pkg::DIV_HIGH_RST;
            ien_q <= irhr_pkg::IEN_RST;
            lctl_q <= irhr_pkg::LCTL_RST;
            cfg_q <= irhr_pkg::CFG_RST;
        end else begin
            if (wr_div_low) div_low_q <= dat_i[7:0];
            if (wr_div_high) div_high_q <= dat_i[7:0];
            if (wr_ien) ien_q <= dat_i[7:0];
            if (wr_lctl) lctl_q <= dat_i[7:0];
            if (wr_cfg) cfg_q <= lane_merge(cfg_q, dat_i, sel_i);
        end
    end

    // Divisor output follows the latches directly
    assign baud_div_o = {div_high_q, div_low_q};

    // ========================================================
    // Pending bits and the level interrupt. The output is registered
    // from the next state so it appears with the bit, not a cycle late.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_q <= 8'h00;
            irq_o <= 1'b0;
        end else begin
            src_q <= src_d;
            irq_o <= |(src_d & ien_eff);
        end
    end

endmodule

`default_nettype wire

//--- verification/irhr_checker.sv
// Port-level checks for the infrared host register bank.
// Assumes binding to irhr_top; one clock, synchronous active-high reset.
`default_nettype none

module irhr_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic tx_ready_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic [15:0] baud_div_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus answer comes exactly one edge after the request
    property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("request not answered in the next cycle");
    property p_ack_drop; ack_o |=> !ack_o; endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("ack held longer than one cycle");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without a request");
    // Read data is zero outside the answer cycle
    property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data not zero while idle");
    property p_rst_quiet;
        $past(rst_i) |-> !ack_o && !irq_o && !tx_valid_o && dat_o == 32'h0;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active right after reset");
    // Staged byte must not change before the transmitter takes it
    property p_tx_hold;
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("staged transmit byte changed or dropped");
    // Divisor only moves on a write
    property p_div_read; cyc_i && !we_i |=> $stable(baud_div_o); endproperty
    a_div_read: assert property (p_div_read)
        else $error("divisor changed on a read");
    property p_div_idle; !cyc_i |=> $stable(baud_div_o); endproperty
    a_div_idle: assert property (p_div_idle)
        else $error("divisor changed with the bus idle");
endmodule

bind irhr_top irhr_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .tx_ready_i(tx_ready_i),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .baud_div_o(baud_div_o), .irq_o(irq_o)
);

`default_nettype wire

//--- verification/irhr_link_model.sv
// Behavioural line coder facing the bank's receive, transmit and tc pins.
// Assumes the bench calls its tasks; all changes follow a rising edge.
`default_nettype none

module irhr_link_model (
    input wire logic clk_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_last_o,
    output logic tx_active_o,
    output logic tx_ready_o,
    output logic dma_tc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];

    // ========================================================
    // Idle levels; stale data is inverted so it never looks valid
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'hA5;
        rx_last_o = 1'b0;
        tx_active_o = 1'b0;
        tx_ready_o = 1'b1;
        dma_tc_o = 1'b0;
    end

    // Collect each byte the transmitter takes
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    end

    task automatic send(input logic [7:0] d, input logic last);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= d;
        rx_last_o <= last;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~d;
        rx_last_o <= 1'b0;
    endtask

    task automatic ready(input logic v);
        @(posedge clk_i);
        tx_ready_o <= v;
    endtask

    // Asks for a byte inside a frame with nothing staged
    task automatic underrun();
        @(posedge clk_i);
        tx_active_o <= 1'b1;
        @(posedge clk_i);
        tx_active_o <= 1'b0;
    endtask

    task automatic tc(input logic v);
        @(posedge clk_i);
        dma_tc_o <= v;
    endtask
endmodule

`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the infrared host register bank.
// Assumes irhr_top, its bound checker and the line-side model.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [irhr_pkg::ADR_W-1:0] adr_i = '0;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic [3:0] lanes = 4'h1;
    logic we_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic [31:0] dat_o, rdat;
    logic ack_o, rx_valid, rx_last, tx_active, tx_ready, tx_valid, tc, irq_o;
    logic [7:0] rx_data, tx_data;
    logic [15:0] baud;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    // Small receive FIFO and gap so overrun and time-out come quickly
    irhr_top #(.RX_DEPTH(4), .GAP_CYCLES(20)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .dat_o(dat_o), .ack_o(ack_o), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .rx_last_i(rx_last), .tx_active_i(tx_active),
        .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .dma_tc_i(tc), .baud_div_o(baud), .irq_o(irq_o)
    );
    irhr_link_model link (
        .clk_i(clk_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_last_o(rx_last),
        .tx_active_o(tx_active), .tx_ready_o(tx_ready), .dma_tc_o(tc)
    );

    // ========================================================
    // Clock and hang guard
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end

    // ========================================================
    // Classic single cycle; waits for ack however long it takes
    task automatic bus(input logic [2:0] idx, input logic w,
                       input logic [7:0] d);
        @(posedge clk_i);
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h000000, d};
        sel_i <= lanes;
        we_i <= w;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rdat = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [2:0] idx, input logic [31:0] e);
        bus(idx, 1'b0, 8'h00);
        ck(rdat, e);
    endtask

    // Irq is checked after its registered update has landed
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_i);
        ck({31'h0, irq_o}, {31'h0, e});
    endtask

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ========================================================
    // Main sequence: reset state, banking, each mode's enables
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(irhr_pkg::IDX_IEN, irhr_pkg::IEN_RST);
        wr(3'h6, 8'hFF);
        rd(3'h6, 32'h0);
        wr(irhr_pkg::IDX_SRC, 8'hFF);
        rd(irhr_pkg::IDX_SRC, 32'h02);
        ck(baud, {irhr_pkg::DIV_HIGH_RST, irhr_pkg::DIV_LOW_RST});
        // Divisor bank versus enables at the same offsets
        wr(irhr_pkg::IDX_LCTL, 8'h80);
        wr(irhr_pkg::IDX_DATA, 8'h5A);
        wr(irhr_pkg::IDX_IEN, 8'hC3);
        rd(irhr_pkg::IDX_DATA, 32'h5A);
        rd(irhr_pkg::IDX_IEN, 32'h0);
        ck(baud, 16'hC35A);
        wr(irhr_pkg::IDX_LCTL, 8'h00);
        rd(irhr_pkg::IDX_IEN, 32'h0);
        wr(irhr_pkg::IDX_IEN, 8'hFF);
        rd(irhr_pkg::IDX_IEN, 32'hFF);
        // A write without byte lane 0 must leave the enables alone
        lanes = 4'h0;
        wr(irhr_pkg::IDX_IEN, 8'h00);
        lanes = 4'h1;
        rd(irhr_pkg::IDX_IEN, 32'hFF);
        wr(irhr_pkg::IDX_LCTL, 8'h80);
        rd(irhr_pkg::IDX_DATA, 32'h5A);
        wr(irhr_pkg::IDX_LCTL, 8'h00);
        // Programmed I/O: transmit threshold and byte order
        wr(irhr_pkg::IDX_IEN, 8'h02);
        link.ready(1'b0);
        for (int i = 0; i < 3; i++) wr(irhr_pkg::IDX_DATA, 8'hA1 + 8'(i));
        rd(irhr_pkg::IDX_SRC, 32'h02);
        irq_is(1'b0);
        link.ready(1'b1);
        while (link.got.size() < 3) @(posedge clk_i);
        for (int i = 0; i < 3; i++) ck(32'(link.got[i]), 32'hA1 + i);
        irq_is(1'b1);
        // Receive threshold, end of frame, last byte read
        wr(irhr_pkg::IDX_IEN, 8'h81);
        link.send(8'h11, 1'b0);
        link.send(8'h22, 1'b1);
        irq_is(1'b1);
        rd(irhr_pkg::IDX_SRC, 32'h83);
        rd(irhr_pkg::IDX_DATA, 32'h11);
        rd(irhr_pkg::IDX_DATA, 32'h22);
        rd(irhr_pkg::IDX_SRC, 32'h07);
        rd(irhr_pkg::IDX_SRC, 32'h02);
        rd(irhr_pkg::IDX_DATA, 32'h0);
        // Overrun, then masking it off
        wr(irhr_pkg::IDX_IEN, 8'h08);
        for (int i = 0; i < 5; i++) link.send(8'h30 + 8'(i), 1'b0);
        irq_is(1'b1);
        wr(irhr_pkg::IDX_IEN, 8'h00);
        irq_is(1'b0);
        rd(irhr_pkg::IDX_SRC, 32'h0B);
        for (int i = 0; i < 4; i++) rd(irhr_pkg::IDX_DATA, 32'h30 + i);
        // DMA: terminal count, status threshold, gap, underrun
        wr(irhr_pkg::IDX_CFG, irhr_pkg::MODE_DMA);
        wr(irhr_pkg::IDX_IEN, 8'h40);
        link.tc(1'b1);
        repeat (3) @(posedge clk_i);
        irq_is(1'b1);
        rd(irhr_pkg::IDX_STAT, 32'h0);
        irq_is(1'b0);
        link.tc(1'b0);
        rd(irhr_pkg::IDX_SRC, 32'h0);
        wr(irhr_pkg::IDX_IEN, 8'h14);
        link.send(8'h44, 1'b1);
        irq_is(1'b1);
        repeat (30) @(posedge clk_i);
        rd(irhr_pkg::IDX_SRC, 32'h14);
        rd(irhr_pkg::IDX_STAT, 32'h1);
        rd(irhr_pkg::IDX_DATA, 32'h44);
        wr(irhr_pkg::IDX_IEN, 8'h20);
        link.underrun();
        irq_is(1'b1);
        rd(irhr_pkg::IDX_SRC, 32'h20);
        // Consumer remote: unused enables have no effect
        wr(irhr_pkg::IDX_CFG, irhr_pkg::MODE_REMOTE);
        wr(irhr_pkg::IDX_IEN, 8'hD4);
        irq_is(1'b0);
        wr(irhr_pkg::IDX_IEN, 8'h02);
        irq_is(1'b1);
        link.underrun();
        rd(irhr_pkg::IDX_SRC, 32'h22);
        close_out();
    end
endmodule

`default_nettype wire
